// file: output_digit_formatter.sv
// Purpose: formats stored measurement digits for a general-purpose interface bus
// Assumes: formatCode and digitCount stay stable while a group is in flight
// Notes: one group is buffered, then sent; ascii digits are bcd in the low nibble
`timescale 1ns/100ps
module output_digit_formatter
   import odf_pkg::*;
#(
   parameter int DW = odf_pkg::DIGIT_W
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // programming
   input wire logic [1:0] formatCode,
   input wire logic [odf_pkg::DIGIT_W-1:0] digitCount,
   // stored digits from memory
   input wire logic [7:0] digitData,
   input wire logic digitValid,
   input wire logic digitLast,
   output logic digitReady,
   // interface bus side
   output logic [7:0] busData,
   output logic busValid,
   input wire logic busAccept,
   output logic busEoi,
   // group status
   output logic digitGroupTerminalCount,
   output logic readDoneFlipflop,
   input wire logic readDoneClear
);
   import odf_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   odf_state_type state, next_state;
   logic [DW-1:0] wrAddr, next_wrAddr;
   logic [DW-1:0] rdAddr, next_rdAddr;
   logic asciiHalf, next_asciiHalf;
   logic groupLast, next_groupLast;
   logic [7:0] next_busData;
   logic next_tcToggle, next_readDone;
   logic [7:0] groupBuf [0:(1<<DW)-1];
   logic [DW-1:0] cnt, presetValue;
   logic cntOne, cntPreset, cntDec;
   logic [DW-1:0] limit;
   logic isAscii, isReversed, loadDone, takeDigit, sendAccept;
   logic [DW-1:0] firstAddr;
   logic [7:0] firstRaw;

   function automatic logic [7:0] shape(input logic [7:0] raw, input logic asc);
      shape = asc ? (CHAR_ZERO | {4'h0, raw[3:0]}) : raw;
   endfunction

   assign isAscii = (formatCode == FMT_ASCII);
   assign isReversed = (formatCode == FMT_REVERSED) || isAscii;
   assign limit = (digitCount == '0) ? DW'(1) : digitCount;
   assign digitReady = (state == ST_LOAD);
   assign busValid = (state != ST_LOAD);
   assign takeDigit = digitReady && digitValid;
   assign loadDone = takeDigit && ((wrAddr + DW'(1)) == limit || digitLast);
   assign sendAccept = (state == ST_SEND) && busAccept;
   assign busEoi = (state == ST_SEND) && !isAscii && groupLast && cntOne;
   assign firstAddr = isReversed ? wrAddr : '0;
   assign firstRaw = (firstAddr == wrAddr) ? digitData : groupBuf[firstAddr];

   // ------------------------------------------------------------
   // digit counter
   // ------------------------------------------------------------
   assign cntPreset = loadDone || ((state == ST_COMMA) && busAccept);
   assign presetValue = loadDone ? DW'(wrAddr + DW'(1)) : limit;
   assign cntDec = sendAccept;

   odf_down_counter #(
      .WIDTH(DW)
   ) digitCounter (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .preset(cntPreset),
      .presetValue(presetValue),
      .dec(cntDec),
      .count(cnt),
      .isOne(cntOne)
   );

   // ------------------------------------------------------------
   // group buffer
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (takeDigit) begin
         groupBuf[wrAddr] <= digitData;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_wrAddr = wrAddr;
      next_rdAddr = rdAddr;
      next_asciiHalf = asciiHalf;
      next_groupLast = groupLast;
      next_busData = busData;
      next_tcToggle = digitGroupTerminalCount;
      next_readDone = readDoneFlipflop && !readDoneClear;
      case (state)
         ST_LOAD: begin
            if (takeDigit) begin
               next_wrAddr = wrAddr + DW'(1);
            end
            if (loadDone) begin
               next_groupLast = digitLast;
               next_rdAddr = firstAddr;
               next_busData = shape(firstRaw, isAscii);
               next_state = ST_SEND;
            end
         end
         ST_SEND: begin
            if (busAccept) begin
               if (cntOne) begin
                  next_tcToggle = !digitGroupTerminalCount;
                  next_readDone = 1'b1;
                  next_wrAddr = '0;
                  if (isAscii && !asciiHalf) begin
                     next_busData = CHAR_COMMA;
                     next_state = ST_COMMA;
                  end else if (isAscii) begin
                     next_busData = CHAR_CR;
                     next_state = ST_CRET;
                  end else begin
                     next_state = ST_LOAD;
                  end
               end else begin
                  next_rdAddr = isReversed ? rdAddr - DW'(1) : rdAddr + DW'(1);
                  next_busData = shape(groupBuf[next_rdAddr], isAscii);
               end
            end
         end
         ST_COMMA: begin
            if (busAccept) begin
               next_asciiHalf = 1'b1;
               next_state = ST_LOAD;
            end
         end
         ST_CRET: begin
            if (busAccept) begin
               next_busData = CHAR_LF;
               next_state = ST_LFEED;
            end
         end
         ST_LFEED: begin
            if (busAccept) begin
               next_asciiHalf = 1'b0;
               next_state = ST_LOAD;
            end
         end
         default: begin
            next_state = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_LOAD;
         wrAddr <= DIGIT_CNT_RESET;
         rdAddr <= DIGIT_CNT_RESET;
         asciiHalf <= 1'b0;
         groupLast <= 1'b0;
         busData <= 8'h00;
         digitGroupTerminalCount <= 1'b0;
         readDoneFlipflop <= 1'b0;
      end else begin
         state <= next_state;
         wrAddr <= next_wrAddr;
         rdAddr <= next_rdAddr;
         asciiHalf <= next_asciiHalf;
         groupLast <= next_groupLast;
         busData <= next_busData;
         digitGroupTerminalCount <= next_tcToggle;
         readDoneFlipflop <= next_readDone;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_reversed_first: assert property (
      loadDone && isReversed && !isAscii |=> busData == $past(digitData))
      else $error("reversed group does not start with last digit");
   a_forward_first: assert property (
      loadDone && !isReversed && wrAddr == '0 |=> busData == $past(digitData))
      else $error("forward group does not start with first digit");
   a_counter_preset: assert property (
      loadDone |=> cnt == DW'($past(wrAddr) + DW'(1)))
      else $error("digit counter not preset to group length");
   a_tc_toggle: assert property (
      $changed(digitGroupTerminalCount) |-> $past(cntOne) && $past(busAccept)
         ##0 readDoneFlipflop)
      else $error("terminal count toggled without group end");
   a_comma_insert: assert property (
      sendAccept && cntOne && isAscii && !asciiHalf
         |=> state == ST_COMMA && busData == CHAR_COMMA)
      else $error("comma not inserted after time digits");
   a_comma_preset: assert property (
      state == ST_COMMA && busAccept |=> state == ST_LOAD && asciiHalf && cnt == limit)
      else $error("comma acceptance does not preset digit counter");
   a_crlf_order: assert property (
      state == ST_CRET && busData == CHAR_CR && busAccept
         |=> state == ST_LFEED && busData == CHAR_LF)
      else $error("line feed does not follow carriage return");
   a_ascii_digit: assert property (
      state == ST_SEND && isAscii |-> busData[7:4] == 4'h3)
      else $error("ascii digit outside digit range");
   a_eoi_binary: assert property (
      busEoi |-> !isAscii && cnt == DW'(1) && busValid)
      else $error("end-or-identify outside binary last byte");
   a_hold_byte: assert property (
      busValid && !busAccept |=> $stable(busData) && busValid)
      else $error("bus byte changed before acceptance");

   c_reversed_group: cover property (
      sendAccept && cntOne && formatCode == FMT_REVERSED);
   c_forward_eoi: cover property (busEoi && busAccept && formatCode == FMT_FORWARD);
   c_ascii_record: cover property (state == ST_LFEED && busAccept);
   c_full_group: cover property (loadDone && wrAddr == DW'(14));
endmodule

// file: odf_pkg.sv
// Purpose: shared constants of the output digit formatter
// Assumes: format code arrives as a two-bit program value
// Notes: code 3 is treated like the plain binary format
package odf_pkg;
   // ------------------------------------------------------------
   // format program codes
   // ------------------------------------------------------------
   localparam logic [1:0] FMT_REVERSED = 2'h0;
   localparam logic [1:0] FMT_ASCII = 2'h1;
   localparam logic [1:0] FMT_FORWARD = 2'h2;

   // ------------------------------------------------------------
   // widths and reset values
   // ------------------------------------------------------------
   localparam int DIGIT_W = 4;
   localparam logic [DIGIT_W-1:0] DIGIT_CNT_RESET = 4'h0;

   // ------------------------------------------------------------
   // punctuation characters and the digit base of an ascii record
   // ------------------------------------------------------------
   localparam logic [7:0] CHAR_COMMA = 8'h2C;
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_LF = 8'h0A;
   localparam logic [7:0] CHAR_ZERO = 8'h30;

   typedef enum logic [2:0] {
      ST_LOAD = 3'h0,
      ST_SEND = 3'h1,
      ST_COMMA = 3'h2,
      ST_CRET = 3'h3,
      ST_LFEED = 3'h4
   } odf_state_type;
endpackage

// file: odf_down_counter.sv
// Purpose: presettable digit down-counter
// Assumes: preset wins over decrement
// Notes: holds at zero
`timescale 1ns/100ps
module odf_down_counter #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // control
   input wire logic preset,
   input wire logic [WIDTH-1:0] presetValue,
   input wire logic dec,
   // state
   output logic [WIDTH-1:0] count,
   output logic isOne
);
   logic [WIDTH-1:0] next_count;

   always_comb begin
      next_count = count;
      if (preset) begin
         next_count = presetValue;
      end else if (dec && count != '0) begin
         next_count = count - WIDTH'(1);
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign isOne = (count == WIDTH'(1));
endmodule

// file: odf_ctrl_model.sv
// Purpose: bus controller model that takes formatted bytes
// Assumes: accept is a one-cycle pulse, driven at the falling edge
// Notes: stall sets the wait before each accept; heldByte is {eoi, data}
`timescale 1ns/100ps
module odf_ctrl_model (
   // clock
   input wire logic core_clk,
   // control
   input wire logic [3:0] stall,
   // bus
   input wire logic busValid,
   input wire logic busEoi,
   input wire logic [7:0] busData,
   output logic busAccept,
   output logic [8:0] heldByte
);
   logic [3:0] waitCnt = 4'h0;
   logic acceptQ = 1'b0;
   logic [8:0] heldQ = 9'h000;
   assign busAccept = acceptQ;
   assign heldByte = heldQ;
   always @(negedge core_clk) begin
      if (acceptQ) begin
         acceptQ <= 1'b0;
         waitCnt <= 4'h0;
      end else if (busValid === 1'b1 && waitCnt >= stall) begin
         acceptQ <= 1'b1;
         heldQ <= {busEoi, busData};
      end else if (busValid === 1'b1) begin
         waitCnt <= waitCnt + 4'h1;
      end
   end
endmodule

// file: output_digit_formatter_bench.sv
// Purpose: self-checking bench of the output digit formatter
// Assumes: inputs change at the falling edge
// Notes: bytes are compared as {eoi, data}
`timescale 1ns/100ps
module output_digit_formatter_bench;
   import odf_pkg::*;
   logic core_clk, sys_rst, digitValid, digitLast, digitReady, readDoneClear;
   logic busValid, busAccept, busEoi, digitGroupTerminalCount, readDoneFlipflop;
   logic [1:0] formatCode;
   logic [3:0] digitCount, stall;
   logic [7:0] digitData, busData;
   logic [8:0] heldByte;
   logic [8:0] rxQ[$];
   logic [8:0] expQ[$];
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;

   output_digit_formatter i_dut (.core_clk, .sys_rst, .formatCode, .digitCount,
      .digitData, .digitValid, .digitLast, .digitReady, .busData, .busValid,
      .busAccept, .busEoi, .digitGroupTerminalCount, .readDoneFlipflop,
      .readDoneClear);
   odf_ctrl_model i_ctrl (.core_clk, .stall, .busValid, .busEoi, .busData,
      .busAccept, .heldByte);

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles++;
      if (busValid === 1'b1 && busAccept === 1'b1) rxQ.push_back(heldByte);
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cfg(input logic [1:0] fmt, input logic [3:0] cnt, input logic [3:0] st);
      @(negedge core_clk);
      formatCode = fmt;
      digitCount = cnt;
      stall = st;
   endtask

   task automatic feed(input logic [7:0] first, input int n, input logic last);
      while (digitReady !== 1'b1) @(negedge core_clk);
      for (int i = 0; i < n; i++) begin
         digitValid = 1'b1;
         digitData = first + 8'(i);
         digitLast = last && (i == n - 1);
         @(negedge core_clk);
      end
      digitValid = 1'b0;
      digitLast = 1'b0;
   endtask

   task automatic drain();
      while (rxQ.size() < expQ.size()) @(negedge core_clk);
      repeat (2) @(negedge core_clk);
      while (expQ.size() > 0) chk(rxQ.pop_front(), expQ.pop_front());
      chk(9'(rxQ.size()), 9'h000);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reversed();
      logic tog;
      cfg(FMT_REVERSED, 4'h3, 4'h0);
      tog = digitGroupTerminalCount;
      expQ = '{9'h003, 9'h002, 9'h001};
      feed(8'h01, 3, 1'b0);
      drain();
      chk({8'h00, digitGroupTerminalCount}, {8'h00, ~tog});
      chk({8'h00, readDoneFlipflop}, 9'h001);
      readDoneClear = 1'b1;
      @(negedge core_clk);
      readDoneClear = 1'b0;
      chk({8'h00, readDoneFlipflop}, 9'h000);
      expQ = '{9'h006, 9'h005, 9'h004};
      feed(8'h04, 3, 1'b0);
      drain();
   endtask

   task automatic t_forward();
      cfg(FMT_FORWARD, 4'h4, 4'h3);
      expQ = '{9'h010, 9'h011, 9'h012, 9'h113};
      feed(8'h10, 4, 1'b1);
      drain();
   endtask

   task automatic t_bounds();
      int c;
      int n;
      for (int k = 0; k < 3; k++) begin
         c = (k == 0) ? 1 : ((k == 1) ? 15 : 0);
         n = (c == 0) ? 1 : c;
         cfg(FMT_REVERSED, 4'(c), 4'h1);
         for (int i = n - 1; i >= 0; i--) expQ.push_back(9'(8'h40 + 8'(i)));
         feed(8'h40, n, 1'b0);
         drain();
      end
   endtask

   task automatic t_ascii();
      cfg(FMT_ASCII, 4'h2, 4'h1);
      expQ = '{9'h032, 9'h031, 9'(CHAR_COMMA), 9'h034, 9'h033, 9'(CHAR_CR), 9'(CHAR_LF)};
      feed(8'h01, 2, 1'b0);
      feed(8'h03, 2, 1'b1);
      drain();
   endtask

   initial begin
      sys_rst = 1'b1;
      digitValid = 1'b0;
      digitLast = 1'b0;
      digitData = 8'h00;
      readDoneClear = 1'b0;
      formatCode = FMT_FORWARD;
      digitCount = 4'h1;
      stall = 4'h0;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      chk({7'h00, digitReady, busValid}, 9'h002);
      sys_rst = 1'b0;
      t_reversed();
      t_forward();
      t_bounds();
      t_ascii();
      t_reversed();
      stop_test();
   end
endmodule
